// ---- rtl/mbrs_sequencer.sv ----
// Brake release sequencer: request output, timers, fault check and registers.
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] Input terminals selected as code 15 carry the release confirmation.
// [RULE2] Output terminals code 20 drive the request high-true, code 120 inverted.
// [RULE3] Fault when confirmation stays unchanged after the request changes.
// [RULE4] The brake releases while the request is high, engages while low.
// [RULE5] Request rises when flux is ready after pre-excitation or run command.
// [RULE6] Request drops at once whenever the drive output is shut off.
// [RULE7] In the zone, speed at threshold then hold time elapses drops the request.
// [RULE8] Zone opens at deceleration start, closes on request drop or new feed.
// [RULE9] Pre-excitation first, then request, then ramp after settle time.
// [RULE10] A run command during settle still leads to the ramp.
// [RULE11] Without pre-excitation run raises the request; ramp waits for settle time.
// [RULE12] Hold timer clears on expiry, output shutoff or a new feed start.
// [RULE13] Settle time programmable 0 to 5 s, default 0.3 s.
// [RULE14] Hold time programmable 0 to 30 s, default 3 s.
// [RULE15] Engage speed threshold programmable 0 to 30 Hz, default 6 Hz.
// [RULE16] The fault flag stays latched until software clears it or reset.
module mbrs_sequencer #(
  parameter int TICK_CYC = mbrs_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_n,
  // Drive status on the core clock.
  input  wire mbrs_pkg::mbrs_drive_t        i_drive,
  // Terminal pins.
  input  wire logic [mbrs_pkg::N_IN-1:0]    i_term_in,
  output logic      [mbrs_pkg::N_OUT-1:0]   o_term_out,
  // Sequencer outputs.
  output logic                              o_release_req,
  output logic                              o_ramp_enable,
  output logic                              o_seq_fault,
  output logic                              o_irq,
  // Register port.
  input  wire mbrs_pkg::mbrs_bus_t          i_bus,
  output logic      [31:0]                  o_rdata
);

  // Clamp a written setting to its allowed maximum.
  function automatic logic [11:0] clamp(input logic [31:0] v, input logic [11:0] mx);
    clamp = (v > {20'h00000, mx}) ? mx : v[11:0];
  endfunction : clamp

  // Decode one byte lane of a select word.
  function automatic logic [7:0] lane(input logic [31:0] w, input int k);
    lane = w[k*8 +: 8];
  endfunction : lane

  logic [11:0]                  settle_time;
  logic [11:0]                  hold_time;
  logic [11:0]                  engage_speed;
  logic [7:0]                   in_sel  [mbrs_pkg::N_IN];
  logic [7:0]                   out_sel [mbrs_pkg::N_OUT];
  logic [mbrs_pkg::N_IRQ-1:0]   irq_stat;
  logic [mbrs_pkg::N_IRQ-1:0]   irq_mask;
  logic [mbrs_pkg::N_IN-1:0]    pin_meta;
  logic [mbrs_pkg::N_IN-1:0]    pin_sync;
  logic                         confirm;
  logic                         cmd_prev;
  logic                         cmd_rise;
  mbrs_pkg::mbrs_state_t        state;
  mbrs_pkg::mbrs_state_t        next_state;
  logic                         next_req;
  logic                         req;
  logic                         req_prev;
  logic                         req_rise;
  logic                         req_fall;
  logic                         settle_done;
  logic                         hold_run;
  logic                         hold_clear;
  logic                         hold_done;
  logic                         chk_pending;
  logic                         chk_done;
  logic                         fault_evt;
  logic                         below_thr;
  logic                         decel_start;
  logic [31:0]                  next_rdata;

  // Pins cross two flops before any logic reads them.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= i_term_in;
      pin_sync <= pin_meta;
    end
  end

  // Any terminal assigned the confirm function contributes to it.
  always_comb
  begin
    confirm = 1'b0;
    for (int i = 0; i < mbrs_pkg::N_IN; i++)
      if (in_sel[i] == mbrs_pkg::FSEL_CONFIRM) // RULE1
        confirm = confirm | pin_sync[i];
  end

  // Output terminals carry the request in either polarity; others idle low.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_term_out <= '0;
    else
      for (int j = 0; j < mbrs_pkg::N_OUT; j++)
        o_term_out[j] <= (out_sel[j] == mbrs_pkg::FSEL_REQ_POS && req) || // RULE2
                         (out_sel[j] == mbrs_pkg::FSEL_REQ_NEG && !req);   // RULE2
  end

  // A start needs a fresh command edge, so a stop is not undone by a held command.
  assign cmd_rise    = (i_drive.premag | i_drive.run) & ~cmd_prev;
  assign below_thr   = i_drive.speed <= {4'h0, engage_speed};
  assign decel_start = !i_drive.run || (i_drive.pos_mode && i_drive.target_reached); // RULE8

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmd_prev <= 1'b0;
    else
      cmd_prev <= i_drive.premag | i_drive.run;
  end

  // Next state and request; output shutoff overrides every other condition.
  always_comb
  begin
    next_state = state;
    next_req   = req;
    if (i_drive.shutoff)
    begin
      next_state = mbrs_pkg::ST_IDLE;
      next_req   = 1'b0; // RULE6
    end
    else
      unique case (state)
        mbrs_pkg::ST_IDLE:
          if (cmd_rise)
            next_state = mbrs_pkg::ST_FLUX;
        mbrs_pkg::ST_FLUX:
          if (!(i_drive.premag || i_drive.run))
            next_state = mbrs_pkg::ST_IDLE;
          else if (i_drive.flux_ok)
          begin
            next_state = mbrs_pkg::ST_SETTLE;
            next_req   = 1'b1; // RULE5 RULE9 RULE11
          end
        mbrs_pkg::ST_SETTLE:
          if (settle_done)
            next_state = i_drive.run ? mbrs_pkg::ST_RUN : mbrs_pkg::ST_HOLD; // RULE10 RULE11
        mbrs_pkg::ST_HOLD:
          if (i_drive.run)
            next_state = mbrs_pkg::ST_RUN; // RULE9
          else if (!i_drive.premag)
          begin
            next_state = mbrs_pkg::ST_IDLE;
            next_req   = 1'b0;
          end
        mbrs_pkg::ST_RUN:
          if (decel_start)
            next_state = mbrs_pkg::ST_ZONE; // RULE8
        mbrs_pkg::ST_ZONE:
          if (i_drive.feed_start && i_drive.run)
            next_state = mbrs_pkg::ST_RUN; // RULE8
          else if (hold_done)
          begin
            next_state = mbrs_pkg::ST_IDLE;
            next_req   = 1'b0; // RULE7
          end
        default:
        begin
          next_state = mbrs_pkg::ST_IDLE;
          next_req   = 1'b0;
        end
      endcase
  end

  // Sequencer state and request register.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state    <= mbrs_pkg::ST_IDLE;
      req      <= 1'b0;
      req_prev <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      req      <= next_req; // RULE4
      req_prev <= req;
    end
  end

  assign req_rise      = req & ~req_prev;
  assign req_fall      = ~req & req_prev;
  assign o_release_req = req;
  assign o_ramp_enable = (state == mbrs_pkg::ST_RUN);

  // Settle timer counts only while the request is up and ramp is held back.
  mbrs_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_settle (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (state != mbrs_pkg::ST_SETTLE),
    .i_run      (state == mbrs_pkg::ST_SETTLE),
    .i_limit    (settle_time),
    .o_done     (settle_done)
  );

  // Hold timer runs in the zone once speed is at or below the threshold.
  assign hold_run   = (state == mbrs_pkg::ST_ZONE) && below_thr; // RULE7
  // Expiry clears it too, as the state leaves the zone on that same edge; feeding
  // the done flag back into the clear would close a combinational loop.
  assign hold_clear = i_drive.shutoff ||
                      (state != mbrs_pkg::ST_ZONE) ||
                      i_drive.feed_start; // RULE12

  mbrs_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_hold (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (hold_clear),
    .i_run      (hold_run),
    .i_limit    (hold_time),
    .o_done     (hold_done)
  );

  // The confirmation has one window to follow each request change.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      chk_pending <= 1'b0;
    else if (req != req_prev)
      chk_pending <= 1'b1;
    else if (chk_done || confirm == req)
      chk_pending <= 1'b0;
  end

  mbrs_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_confirm (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (!chk_pending || req != req_prev),
    .i_run      (chk_pending),
    .i_limit    (12'(mbrs_pkg::CONFIRM_TICKS)),
    .o_done     (chk_done)
  );

  assign fault_evt   = chk_pending && chk_done && (confirm != req); // RULE3
  assign o_seq_fault = irq_stat[mbrs_pkg::IRQ_FAULT];
  assign o_irq       = |(irq_stat & irq_mask);

  // Sticky status: a new event in the clearing cycle keeps its bit set.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_stat <= '0;
    else
    begin
      for (int b = 0; b < mbrs_pkg::N_IRQ; b++)
        if (i_bus.wr && i_bus.addr == mbrs_pkg::A_IRQ_STAT && i_bus.wdata[b])
          irq_stat[b] <= 1'b0;
      if (fault_evt)
        irq_stat[mbrs_pkg::IRQ_FAULT] <= 1'b1; // RULE16
      if (req_rise)
        irq_stat[mbrs_pkg::IRQ_RISE] <= 1'b1;
      if (req_fall)
        irq_stat[mbrs_pkg::IRQ_FALL] <= 1'b1;
    end
  end

  // Settings registers; out-of-range writes clamp to the maximum.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      settle_time  <= mbrs_pkg::SETTLE_RST; // RULE13
      hold_time    <= mbrs_pkg::HOLD_RST;   // RULE14
      engage_speed <= mbrs_pkg::ENGAGE_RST; // RULE15
      irq_mask     <= '0;
    end
    else if (i_bus.wr)
      unique case (i_bus.addr)
        mbrs_pkg::A_SETTLE:   settle_time  <= clamp(i_bus.wdata, mbrs_pkg::SETTLE_MAX);
        mbrs_pkg::A_HOLD:     hold_time    <= clamp(i_bus.wdata, mbrs_pkg::HOLD_MAX);
        mbrs_pkg::A_ENGAGE:   engage_speed <= clamp(i_bus.wdata, mbrs_pkg::ENGAGE_MAX);
        mbrs_pkg::A_IRQ_MASK: irq_mask     <= i_bus.wdata[mbrs_pkg::N_IRQ-1:0];
        default:              irq_mask     <= irq_mask;
      endcase
  end

  // Terminal function selects, four bytes to a word.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < mbrs_pkg::N_IN; i++)
        in_sel[i] <= 8'h00;
      for (int j = 0; j < mbrs_pkg::N_OUT; j++)
        out_sel[j] <= 8'h00;
    end
    else if (i_bus.wr)
    begin
      for (int i = 0; i < mbrs_pkg::N_IN; i++)
        if (i_bus.addr == mbrs_pkg::A_IN_SEL0 + 8'(4 * (i / 4)))
          in_sel[i] <= lane(i_bus.wdata, i % 4);
      for (int j = 0; j < mbrs_pkg::N_OUT; j++)
        if (i_bus.addr == mbrs_pkg::A_OUT_SEL0 + 8'(4 * (j / 4)))
          out_sel[j] <= lane(i_bus.wdata, j % 4);
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (i_bus.addr)
      mbrs_pkg::A_SETTLE:   next_rdata = {20'h00000, settle_time};
      mbrs_pkg::A_HOLD:     next_rdata = {20'h00000, hold_time};
      mbrs_pkg::A_ENGAGE:   next_rdata = {20'h00000, engage_speed};
      mbrs_pkg::A_STATE:    next_rdata = {25'h0000000, state, 1'b0, confirm, o_ramp_enable, req};
      mbrs_pkg::A_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
      mbrs_pkg::A_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
      default:
      begin
        for (int i = 0; i < mbrs_pkg::N_IN; i++)
          if (i_bus.addr == mbrs_pkg::A_IN_SEL0 + 8'(4 * (i / 4)))
            next_rdata[(i % 4) * 8 +: 8] = in_sel[i];
        for (int j = 0; j < mbrs_pkg::N_OUT; j++)
          if (i_bus.addr == mbrs_pkg::A_OUT_SEL0 + 8'(4 * (j / 4)))
            next_rdata[(j % 4) * 8 +: 8] = out_sel[j];
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else if (i_bus.rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= '0;
  end

endmodule : mbrs_sequencer

// ---- rtl/mbrs_pkg.sv ----
// Package with the constants, register map and carrier types of the brake sequencer.
package mbrs_pkg;

  // Clock and timebase; all programmable times count 10 ms ticks.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 10_000_000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Confirmation window after the request changes, in milliseconds.
  localparam int CONFIRM_MS    = 500;
  localparam int CONFIRM_TICKS = (CONFIRM_MS * 1_000_000) / TICK_NS;

  // Terminal counts and function selection codes.
  localparam int N_IN  = 12;
  localparam int N_OUT = 7;
  localparam logic [7:0] FSEL_CONFIRM  = 8'h0f;
  localparam logic [7:0] FSEL_REQ_POS  = 8'h14;
  localparam logic [7:0] FSEL_REQ_NEG  = 8'h78;

  // Programmable settings: times in 10 ms, speed in 0.01 Hz.
  localparam logic [11:0] SETTLE_MAX = 12'h1f4;
  localparam logic [11:0] SETTLE_RST = 12'h01e;
  localparam logic [11:0] HOLD_MAX   = 12'hbb8;
  localparam logic [11:0] HOLD_RST   = 12'h12c;
  localparam logic [11:0] ENGAGE_MAX = 12'hbb8;
  localparam logic [11:0] ENGAGE_RST = 12'h258;

  // Register byte addresses.
  localparam logic [7:0] A_SETTLE   = 8'h00;
  localparam logic [7:0] A_HOLD     = 8'h04;
  localparam logic [7:0] A_ENGAGE   = 8'h08;
  localparam logic [7:0] A_IN_SEL0  = 8'h0c;
  localparam logic [7:0] A_OUT_SEL0 = 8'h18;
  localparam logic [7:0] A_STATE    = 8'h20;
  localparam logic [7:0] A_IRQ_STAT = 8'h24;
  localparam logic [7:0] A_IRQ_MASK = 8'h28;
  localparam int N_IN_WORDS  = 3;
  localparam int N_OUT_WORDS = 2;

  // Interrupt status bit positions.
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_RISE  = 1;
  localparam int IRQ_FALL  = 2;
  localparam int N_IRQ     = 3;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_FLUX, ST_SETTLE, ST_HOLD, ST_RUN, ST_ZONE
  } mbrs_state_t;

  // Drive status from logic on the same clock.
  typedef struct packed {
    logic        premag;
    logic        run;
    logic        flux_ok;
    logic        shutoff;
    logic        pos_mode;
    logic        target_reached;
    logic        feed_start;
    logic [15:0] speed;
  } mbrs_drive_t;

  // Register bus request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mbrs_bus_t;

endpackage : mbrs_pkg

// ---- rtl/mbrs_timer.sv ----
// Tick-based timer used for the settle, hold and confirmation intervals.
`timescale 1ns/100ps
module mbrs_timer #(
  parameter int TICK_CYC = mbrs_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Control.
  input  wire logic        i_clear,
  input  wire logic        i_run,
  input  wire logic [11:0] i_limit,
  // Status.
  output logic             o_done
);

  localparam int PW = $clog2(TICK_CYC + 1);
  localparam logic [PW-1:0] PLAST = PW'(TICK_CYC - 1);

  logic [PW-1:0] presc;
  logic [11:0]   ticks;

  // Prescaler restarts with the timer so every interval is full length.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      presc <= '0;
    else if (i_clear || !i_run || presc == PLAST)
      presc <= '0;
    else
      presc <= presc + PW'(1);
  end

  // Tick counter saturates at the limit; a zero limit is done at once.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ticks <= '0;
    else if (i_clear)
      ticks <= '0;
    else if (i_run && presc == PLAST && ticks < i_limit)
      ticks <= ticks + 12'h001;
  end

  assign o_done = i_run && !i_clear && (ticks >= i_limit);

endmodule : mbrs_timer

// ---- verification/mbrs_brake_model.sv ----
// Behavioural mechanical brake with a release confirmation contact.
`timescale 1ns/100ps
module mbrs_brake_model #(
  parameter int DELAY = 20
) (
  // Clock.
  input  wire logic i_core_clk,
  // Request from the drive and fault injection.
  input  wire logic i_req,
  input  wire logic i_stuck,
  // Confirmation contact.
  output logic      o_confirm
);
  int   cnt  = 0;
  logic conf = 1'b0;

  // The contact follows the request after a mechanical delay; a stuck brake never moves.
  always @(posedge i_core_clk)
  begin
    if (i_stuck || i_req == conf)
      cnt <= 0;
    else if (cnt < DELAY)
      cnt <= cnt + 1;
    else
      conf <= i_req;
  end

  // One driver for the contact; it starts engaged.
  assign o_confirm = conf;
endmodule : mbrs_brake_model

// ---- verification/mbrs_sequencer_chk.sv ----
// Concurrent checks on the ports of the brake release sequencer.
`timescale 1ns/100ps
module mbrs_sequencer_chk #(
  parameter int TICK_CYC = 10
) (
  // Clock and reset.
  input wire logic                       i_core_clk,
  input wire logic                       i_rst_n,
  // Drive status and pins.
  input wire mbrs_pkg::mbrs_drive_t      i_drive,
  input wire logic [mbrs_pkg::N_IN-1:0]  i_term_in,
  input wire logic [mbrs_pkg::N_OUT-1:0] o_term_out,
  // Sequencer outputs.
  input wire logic                       o_release_req,
  input wire logic                       o_ramp_enable,
  input wire logic                       o_seq_fault,
  input wire logic                       o_irq,
  // Register port.
  input wire mbrs_pkg::mbrs_bus_t        i_bus,
  input wire logic [31:0]                o_rdata
);
  // All checks share the core clock and its reset.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_shutoff_drops_req: assert property (i_drive.shutoff |=> !o_release_req)
    else $error("request high after shutoff");
  a_req_needs_flux: assert property ($rose(o_release_req) |-> $past(i_drive.flux_ok))
    else $error("request rose without flux");
  a_ramp_with_req: assert property (o_ramp_enable |-> o_release_req)
    else $error("ramp without request");
  a_ramp_needs_run: assert property ($rose(o_ramp_enable) |-> $past(i_drive.run))
    else $error("ramp without run command");
  // Leaving the run state other than by shutoff always passes through the zone.
  a_drop_from_zone: assert property ($fell(o_release_req) |->
    $past(i_drive.shutoff) || !$past(o_ramp_enable))
    else $error("request dropped while ramping");
  a_fault_sticky: assert property (o_seq_fault && !(i_bus.wr && i_bus.wdata[0] &&
    i_bus.addr == mbrs_pkg::A_IRQ_STAT) |=> o_seq_fault)
    else $error("fault flag lost");
  // A fresh change opens a confirmation window, so no fault can follow at once.
  a_fault_not_early: assert property ($changed(o_release_req) |=> !$rose(o_seq_fault) [*8])
    else $error("fault right after change");
  a_term_follows: assert property ($changed(o_term_out) |->
    $past(o_release_req) != $past(o_release_req, 2) || $past(i_bus.wr)
    || $past(i_bus.wr, 2))
    else $error("terminal moved without cause");
endmodule : mbrs_sequencer_chk

bind mbrs_sequencer mbrs_sequencer_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_drive(i_drive), .i_term_in(i_term_in),
  .o_term_out(o_term_out), .o_release_req(o_release_req), .o_ramp_enable(o_ramp_enable),
  .o_seq_fault(o_seq_fault), .o_irq(o_irq), .i_bus(i_bus), .o_rdata(o_rdata));

// ---- verification/test_motor_brake_release_sequencer.sv ----
// Self-checking bench for the brake release sequencer with a brake model.
`timescale 1ns/100ps
module test_motor_brake_release_sequencer;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] rst;
    logic [31:0] w;
    logic [31:0] exp;
  } mbrs_row_t;

  logic                  clk;
  logic                  rst_n;
  mbrs_pkg::mbrs_drive_t drv;
  mbrs_pkg::mbrs_bus_t   bus;
  logic [6:0]            term_out;
  logic                  req;
  logic                  ramp;
  logic                  fault;
  logic                  irq;
  logic                  confirm;
  logic                  stuck;
  logic [31:0]           rdata;
  logic [31:0]           d;
  int                    errors;
  int                    n_tests;
  int                    n;
  // Reset value, written value and expected readback of six registers and one unmapped address.
  mbrs_row_t rows [7] = '{
    '{mbrs_pkg::A_SETTLE, 32'h1e, 32'h3e8, 32'h1f4},
    '{mbrs_pkg::A_HOLD, 32'h12c, 32'hfff, 32'hbb8},
    '{mbrs_pkg::A_ENGAGE, 32'h258, 32'hfff, 32'hbb8},
    '{mbrs_pkg::A_IN_SEL0, 32'h0, 32'h0f000000, 32'h0f000000},
    '{mbrs_pkg::A_OUT_SEL0, 32'h0, 32'h7814, 32'h7814},
    '{mbrs_pkg::A_IRQ_MASK, 32'h0, 32'h1, 32'h1},
    '{8'h40, 32'h0, 32'h5, 32'h0}};

  // Tick shortened to ten cycles; confirmation contact sits on terminal 3.
  mbrs_sequencer #(.TICK_CYC(10)) DUT (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_drive(drv), .i_term_in({8'h00, confirm, 3'h0}),
    .o_term_out(term_out), .o_release_req(req), .o_ramp_enable(ramp), .o_seq_fault(fault),
    .o_irq(irq), .i_bus(bus), .o_rdata(rdata));
  mbrs_brake_model #(.DELAY(20)) u_brake (
    .i_core_clk(clk), .i_req(term_out[0]), .i_stuck(stuck), .o_confirm(confirm));

  task report_and_stop;
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task step(input int c);
    repeat (c) @(posedge clk);
  endtask : step

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  function logic pick(input int w);
    case (w)
      0: return req;
      1: return ramp;
      default: return fault;
    endcase
  endfunction : pick

  // Bounded wait; n returns the cycles spent.  It starts just past the edge so the
  // design's update at that edge is seen.
  task waitfor(input int w, input logic v);
    n = 0;
    #1;
    while (pick(w) !== v)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000)
      begin
        errors++;
        report_and_stop();
      end
    end
  endtask : waitfor

  // Free running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    drv = '0;
    bus = '0;
    stuck = 1'b0;
    errors = 0;
    n_tests = 0;
    step(5);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a, d);
      chk(d, rows[i].rst);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].exp);
    end
    // Short settle and hold times keep the run brief.
    wr(mbrs_pkg::A_SETTLE, 32'h3);
    wr(mbrs_pkg::A_HOLD, 32'h5);
    wr(mbrs_pkg::A_ENGAGE, 32'h64);
    // Run without pre-excitation; flux late.
    step(1);
    drv.run <= 1'b1;
    drv.speed <= 16'h1000;
    step(5);
    drv.flux_ok <= 1'b1;
    #1;
    chk(req, 1'b0);
    chk(term_out, 7'h02);
    waitfor(0, 1'b1);
    chk(ramp, 1'b0);
    waitfor(1, 1'b1);
    chk(n >= 20 && n <= 45, 1'b1);
    chk(term_out, 7'h01);
    step(10);
    rd(mbrs_pkg::A_STATE, d);
    chk(d, 32'h47);
    // Stop: zone holds while speed is above the threshold.
    step(1);
    drv.run <= 1'b0;
    step(100);
    drv.speed <= 16'h0050;
    #1;
    chk({ramp, req}, 2'b01);
    waitfor(0, 1'b0);
    chk(n >= 40 && n <= 65, 1'b1);
    step(600);
    // Pre-excitation first, run arriving inside the settle time, then shutoff.
    drv.premag <= 1'b1;
    drv.speed <= 16'h1000;
    #1;
    chk(fault, 1'b0);
    waitfor(0, 1'b1);
    step(10);
    drv.run <= 1'b1;
    waitfor(1, 1'b1);
    chk(ramp, 1'b1);
    step(1);
    drv.shutoff <= 1'b1;
    step(1);
    drv.shutoff <= 1'b0;
    drv.premag <= 1'b0;
    drv.run <= 1'b0;
    #1;
    chk({ramp, req}, 2'b00);
    step(600);
    // A new feed start in the zone clears the partly counted hold time.
    drv.run <= 1'b1;
    waitfor(1, 1'b1);
    step(1);
    drv.run <= 1'b0;
    drv.speed <= 16'h0050;
    step(30);
    drv.feed_start <= 1'b1;
    drv.run <= 1'b1;
    step(1);
    drv.feed_start <= 1'b0;
    waitfor(1, 1'b1);
    // Second stop by reaching the target in position feed, run still held.
    step(1);
    drv.pos_mode <= 1'b1;
    drv.target_reached <= 1'b1;
    waitfor(0, 1'b0);
    chk(n >= 40 && n <= 65, 1'b1);
    step(1);
    drv.run <= 1'b0;
    drv.pos_mode <= 1'b0;
    drv.target_reached <= 1'b0;
    step(600);
    // Stuck brake: fault latches, interrupt masked, unmasked and cleared.
    stuck <= 1'b1;
    drv.run <= 1'b1;
    drv.speed <= 16'h1000;
    waitfor(2, 1'b1);
    chk(irq, 1'b1);
    rd(mbrs_pkg::A_STATE, d);
    chk(d, 32'h43);
    step(100);
    #1;
    chk(fault, 1'b1);
    wr(mbrs_pkg::A_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(mbrs_pkg::A_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(mbrs_pkg::A_IRQ_STAT, 32'h7);
    chk({irq, fault}, 2'b00);
    step(1);
    drv.shutoff <= 1'b1;
    drv.run <= 1'b0;
    step(2);
    // Reset after shutoff: terminals drop at once and the hold time returns to its default.
    rst_n <= 1'b0;
    #1;
    chk(term_out, 7'h00);
    step(2);
    rst_n <= 1'b1;
    rd(mbrs_pkg::A_HOLD, d);
    chk(d, 32'h12c);
    report_and_stop();
  end
endmodule : test_motor_brake_release_sequencer
